// >>> logic/sidp_pkg.sv
package sidp_pkg;
  // node identifier layout
  localparam int FAMILY_LSB = 0;
  localparam int SERIAL_LSB = 8;
  localparam int CHECK_LSB = 56;
  localparam int ID_BITS = 64;
  localparam int BODY_BITS = 56;
  // check generator polynomial x^8+x^5+x^4+1, reflected form
  localparam logic [7:0] CHECK_POLY_REFL = 8'h8c;
  localparam logic [7:0] CHECK_INIT = 8'h00;
  // identity command codes
  localparam logic [7:0] CMD_READ_ID = 8'h33;
  localparam logic [7:0] CMD_SELECT = 8'h55;
  localparam logic [7:0] CMD_SEARCH = 8'hf0;
  localparam logic [7:0] CMD_SKIP = 8'hcc;
  localparam logic [7:0] CMD_RESUME = 8'ha5;
  localparam logic [7:0] CMD_FAST_SKIP = 8'h3c;
  localparam logic [7:0] CMD_FAST_SELECT = 8'h69;
  // user memory
  localparam logic [4:0] MEM_FIRST = 5'h00;
  localparam logic [4:0] MEM_LAST = 5'h17;
  localparam int MEM_BYTES = 24;
  localparam int MEM_BLOCKS = 6;
  localparam logic [7:0] MEM_ERASED = 8'h00;
  // timing
  localparam int CLK_MHZ = 200;
  localparam int RESET_LOW_US = 480;
  localparam int RESET_LOW_CYC = RESET_LOW_US * CLK_MHZ;
  localparam int FAST_RESET_US = 48;
  localparam int FAST_RESET_CYC = FAST_RESET_US * CLK_MHZ;
  localparam int SAMPLE_NS = 30;
  localparam int SAMPLE_CYC = (SAMPLE_NS * CLK_MHZ + 999) / 1000;
  localparam int FAST_SAMPLE_NS = 5;
  localparam int FAST_SAMPLE_CYC = 1;
  localparam int PRES_WAIT_US = 30;
  localparam int PRES_WAIT_CYC = PRES_WAIT_US * CLK_MHZ;
  localparam int PRES_LOW_US = 120;
  localparam int PRES_LOW_CYC = PRES_LOW_US * CLK_MHZ;
  localparam int FAST_PRES_WAIT_US = 3;
  localparam int FAST_PRES_WAIT_CYC = FAST_PRES_WAIT_US * CLK_MHZ;
  localparam int FAST_PRES_LOW_US = 12;
  localparam int FAST_PRES_LOW_CYC = FAST_PRES_LOW_US * CLK_MHZ;
  localparam int DRIVE_US = 30;
  localparam int DRIVE_CYC = DRIVE_US * CLK_MHZ;
  localparam int FAST_DRIVE_US = 2;
  localparam int FAST_DRIVE_CYC = FAST_DRIVE_US * CLK_MHZ;
  typedef enum logic [2:0] {
    SIDP_IDLE = 3'b000,
    SIDP_ROMCMD = 3'b001,
    SIDP_ROMDATA = 3'b011,
    SIDP_FUNC = 3'b010,
    SIDP_MUTE = 3'b110
  } sidp_state_e;
endpackage

// >>> logic/sidp_crc8.sv
`timescale 1ns/100ps
module sidp_crc8 (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic shift_en,
  input wire logic bit_in,
  output logic [7:0] crc
);
  logic fb;
  assign fb = crc[0] ^ bit_in;
  // ---------------------------------
  // serial check register
  // ---------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst || clear) begin
      // RL8: cleared first
      crc <= sidp_pkg::CHECK_INIT;
    end else if (shift_en) begin
      // RL7: xor feedback taps
      crc <= {1'b0, crc[7:1]} ^ (fb ? sidp_pkg::CHECK_POLY_REFL : 8'h00);
    end
  end
endmodule

// >>> logic/sidp_slave.sv
`timescale 1ns/100ps
// Overview of operation
// RL1: master sends an identity command after each bus reset.
// RL2: fast skip or fast select done at standard speed enters fast mode.
// RL3: function commands accepted only after a successful identity command.
// RL4: all bytes travel least significant bit first.
// RL5: identifier is family code, 48-bit serial, check byte on top.
// RL6: check byte covers the low 56 identifier bits.
// RL7: check uses x^8+x^5+x^4+1 shift register with xor feedback.
// RL8: check register cleared, then bits enter from family code lsb.
// RL9: serial bits follow family bits; register then holds check.
// RL10: shifting the check byte through leaves all zeros.
// RL11: identifier acts as node address on a shared bus.
// RL12: user memory spans byte addresses 00h to 17h.
// RL13: unprogrammed bytes read as 00h.
// RL14: programming writes one aligned 4-byte block, any bit value.
// RL15: written block becomes write-protected, further programs refused.
// RL16: identity commands are single 8-bit codes.
// RL17: bus reset of 480 us or more clears fast mode.
// RL18: after select code 55h and identifier, only exact match responds.
// RL19: unknown identity code mutes the device until next reset.
// RL20: program to protected block leaves contents unchanged.
module sidp_slave #(
  parameter logic [7:0] FAMILY_CODE = 8'h5a, // arbitrary value
  parameter logic [47:0] SERIAL_NUM = 48'h0000_1234_5678, // arbitrary value
  parameter int RESET_CYC = sidp_pkg::RESET_LOW_CYC,
  parameter int FAST_RESET_CYC = sidp_pkg::FAST_RESET_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic bus_in,
  output logic bus_out,
  output logic bus_oe_n,
  output logic fast_mode_flag,
  output logic func_active,
  output logic [7:0] func_cmd,
  output logic func_cmd_valid,
  output logic [7:0] func_rx_byte,
  output logic func_rx_valid,
  input wire logic [7:0] func_tx_byte,
  input wire logic func_tx_load,
  input wire logic [4:0] mem_addr,
  output logic [7:0] mem_rdata,
  input wire logic prog_req,
  input wire logic [31:0] prog_data,
  output logic prog_done,
  output logic prog_refused,
  output logic [63:0] node_identifier,
  output logic id_check_ok
);
  localparam int RW = 17;
  logic s1_reg, s2_reg, s3_reg;
  logic [RW-1:0] low_cnt_reg;
  logic [RW-1:0] slot_cnt_reg;
  logic [RW-1:0] drv_cnt_reg;
  logic in_slot_reg;
  logic rst_pulse, bit_strobe, sampled_bit;
  sidp_pkg::sidp_state_e state_reg;
  logic [7:0] sh_reg;
  logic [6:0] bcnt_reg;
  logic [1:0] trip_reg;
  logic resume_reg, search_ok_reg, match_ok_reg, pend_fast_reg;
  logic [7:0] cur_cmd_reg;
  logic tx_bit;
  logic [7:0] tx_reg;
  logic [2:0] txc_reg;
  logic tx_active_reg;
  logic [7:0] mem_reg [sidp_pkg::MEM_BYTES];
  logic [sidp_pkg::MEM_BLOCKS-1:0] prot_reg;
  logic [7:0] crc_val;
  logic [6:0] crc_cnt_reg;
  logic pres_reg;
  logic [RW-1:0] pres_cnt_reg;
  // ---------------------------------
  // identifier and its check byte
  // ---------------------------------
  logic [55:0] id_body;
  // RL5: identifier layout
  assign id_body = {SERIAL_NUM, FAMILY_CODE};
  logic crc_bit;
  // RL6: check over body bits, then RL9/RL10 self test
  sidp_crc8 sidp_crc8_inst (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clear(1'b0),
    .shift_en(crc_cnt_reg < 7'(sidp_pkg::ID_BITS)),
    .bit_in(crc_bit),
    .crc(crc_val)
  );
  logic [7:0] check_reg;
  // check bit 0 taken live, it is only stored on this same edge
  assign crc_bit = (crc_cnt_reg < 7'(sidp_pkg::BODY_BITS)) ? id_body[crc_cnt_reg[5:0]] :
    (crc_cnt_reg == 7'(sidp_pkg::BODY_BITS)) ? crc_val[0] : check_reg[crc_cnt_reg[2:0]];
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      crc_cnt_reg <= 7'h00;
      check_reg <= 8'h00;
    end else if (crc_cnt_reg < 7'(sidp_pkg::ID_BITS)) begin
      crc_cnt_reg <= crc_cnt_reg + 7'h01;
      // RL9: register holds check after last serial bit
      if (crc_cnt_reg == 7'(sidp_pkg::BODY_BITS)) begin
        check_reg <= crc_val;
      end
    end
  end
  assign node_identifier = {check_reg, id_body};
  // RL10: all zero after check byte shifted
  assign id_check_ok = (crc_cnt_reg == 7'(sidp_pkg::ID_BITS)) && (crc_val == 8'h00);
  // ---------------------------------
  // pin sampling and slot timing
  // ---------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
    end else begin
      s1_reg <= bus_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  always_ff @(posedge mclk) begin
    // own presence low is no bus reset
    if (sys_rst || s2_reg || pres_reg) begin
      low_cnt_reg <= '0;
    end else if (low_cnt_reg != '1) begin
      low_cnt_reg <= low_cnt_reg + 1'b1;
    end
  end
  // speed at the falling edge, so a slow slot ending fast mode entry is no reset
  logic fall_fast_reg;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fall_fast_reg <= 1'b0;
    end else if (!s2_reg && s3_reg) begin
      fall_fast_reg <= fast_mode_flag;
    end
  end
  // RL17: long low is a bus reset
  assign rst_pulse = s2_reg && !s3_reg &&
    (low_cnt_reg >= RW'(fall_fast_reg ? FAST_RESET_CYC : RESET_CYC));
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      in_slot_reg <= 1'b0;
      slot_cnt_reg <= '0;
    end else if (!s2_reg && s3_reg && !pres_reg) begin
      in_slot_reg <= 1'b1;
      slot_cnt_reg <= '0;
    end else if (in_slot_reg) begin
      slot_cnt_reg <= slot_cnt_reg + 1'b1;
      if (bit_strobe) begin
        in_slot_reg <= 1'b0;
      end
    end
  end
  assign bit_strobe = in_slot_reg && (slot_cnt_reg ==
    RW'(fast_mode_flag ? sidp_pkg::FAST_DRIVE_CYC / 2 : sidp_pkg::DRIVE_CYC / 2));
  assign sampled_bit = s2_reg;
  // ---------------------------------
  // presence pulse and bit driving
  // ---------------------------------
  logic [RW-1:0] pres_rise, pres_end;
  assign pres_rise = RW'(fast_mode_flag ? sidp_pkg::FAST_PRES_WAIT_CYC : sidp_pkg::PRES_WAIT_CYC);
  assign pres_end = pres_rise +
    RW'(fast_mode_flag ? sidp_pkg::FAST_PRES_LOW_CYC : sidp_pkg::PRES_LOW_CYC);
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pres_reg <= 1'b0;
      pres_cnt_reg <= '0;
    end else if (rst_pulse) begin
      pres_reg <= 1'b1;
      pres_cnt_reg <= '0;
    end else if (pres_reg) begin
      pres_cnt_reg <= pres_cnt_reg + 1'b1;
      if (pres_cnt_reg == pres_end) begin
        pres_reg <= 1'b0;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      drv_cnt_reg <= '0;
    end else if (!s2_reg && s3_reg && !tx_bit && !pres_reg) begin
      drv_cnt_reg <= RW'(fast_mode_flag ? sidp_pkg::FAST_DRIVE_CYC : sidp_pkg::DRIVE_CYC);
    end else if (drv_cnt_reg != '0) begin
      drv_cnt_reg <= drv_cnt_reg - 1'b1;
    end
  end
  always_comb begin
    tx_bit = 1'b1;
    if (state_reg == sidp_pkg::SIDP_ROMDATA && cur_cmd_reg == sidp_pkg::CMD_READ_ID) begin
      tx_bit = node_identifier[bcnt_reg[5:0]];
    end else if (state_reg == sidp_pkg::SIDP_ROMDATA &&
                 cur_cmd_reg == sidp_pkg::CMD_SEARCH && trip_reg != 2'd2) begin
      tx_bit = search_ok_reg ? (node_identifier[bcnt_reg[5:0]] ^ trip_reg[0]) : 1'b1;
    end else if (tx_active_reg) begin
      tx_bit = tx_reg[txc_reg];
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bus_out <= 1'b1;
      bus_oe_n <= 1'b1;
    end else begin
      bus_out <= 1'b0;
      bus_oe_n <= !((pres_reg && pres_cnt_reg >= pres_rise) ||
                    (drv_cnt_reg != '0));
    end
  end
  // ---------------------------------
  // identity and function sequencing
  // ---------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg <= sidp_pkg::SIDP_IDLE;
      sh_reg <= 8'h00;
      bcnt_reg <= 7'h00;
      trip_reg <= 2'd0;
      cur_cmd_reg <= 8'h00;
      resume_reg <= 1'b0;
      search_ok_reg <= 1'b0;
      match_ok_reg <= 1'b0;
      pend_fast_reg <= 1'b0;
      fast_mode_flag <= 1'b0;
      func_cmd <= 8'h00;
      func_cmd_valid <= 1'b0;
      func_rx_byte <= 8'h00;
      func_rx_valid <= 1'b0;
    end else begin
      func_cmd_valid <= 1'b0;
      func_rx_valid <= 1'b0;
      if (rst_pulse) begin
        state_reg <= sidp_pkg::SIDP_ROMCMD;
        bcnt_reg <= 7'h00;
        // RL17: long reset back to standard speed
        if (low_cnt_reg >= RW'(RESET_CYC)) begin
          fast_mode_flag <= 1'b0;
        end
      end else if (bit_strobe) begin
        // RL4: lsb first shifting
        sh_reg <= {sampled_bit, sh_reg[7:1]};
        bcnt_reg <= bcnt_reg + 7'h01;
        case (state_reg)
          sidp_pkg::SIDP_ROMCMD: begin
            if (bcnt_reg == 7'd7) begin
              // RL16: one 8-bit identity code
              cur_cmd_reg <= {sampled_bit, sh_reg[7:1]};
              bcnt_reg <= 7'h00;
              trip_reg <= 2'd0;
              search_ok_reg <= 1'b1;
              match_ok_reg <= 1'b1;
              case ({sampled_bit, sh_reg[7:1]})
                sidp_pkg::CMD_READ_ID, sidp_pkg::CMD_SELECT, sidp_pkg::CMD_SEARCH: begin
                  state_reg <= sidp_pkg::SIDP_ROMDATA;
                end
                sidp_pkg::CMD_FAST_SELECT: begin
                  state_reg <= sidp_pkg::SIDP_ROMDATA;
                  pend_fast_reg <= !fast_mode_flag;
                  fast_mode_flag <= 1'b1;
                end
                sidp_pkg::CMD_SKIP: begin
                  state_reg <= sidp_pkg::SIDP_FUNC;
                  resume_reg <= 1'b0;
                end
                sidp_pkg::CMD_FAST_SKIP: begin
                  // RL2: fast mode after fast skip
                  state_reg <= sidp_pkg::SIDP_FUNC;
                  resume_reg <= 1'b0;
                  fast_mode_flag <= 1'b1;
                end
                sidp_pkg::CMD_RESUME: begin
                  state_reg <= resume_reg ? sidp_pkg::SIDP_FUNC : sidp_pkg::SIDP_MUTE;
                end
                default: begin
                  // RL19: unknown code mutes until reset
                  state_reg <= sidp_pkg::SIDP_MUTE;
                end
              endcase
            end
          end
          sidp_pkg::SIDP_ROMDATA: begin
            if (cur_cmd_reg == sidp_pkg::CMD_READ_ID) begin
              if (bcnt_reg == 7'd63) begin
                state_reg <= sidp_pkg::SIDP_FUNC;
              end
            end else if (cur_cmd_reg == sidp_pkg::CMD_SEARCH) begin
              bcnt_reg <= bcnt_reg;
              trip_reg <= (trip_reg == 2'd2) ? 2'd0 : trip_reg + 2'd1;
              if (trip_reg == 2'd2) begin
                bcnt_reg <= bcnt_reg + 7'h01;
                if (sampled_bit != node_identifier[bcnt_reg[5:0]]) begin
                  state_reg <= sidp_pkg::SIDP_MUTE;
                  resume_reg <= 1'b0;
                end else if (bcnt_reg == 7'd63) begin
                  state_reg <= sidp_pkg::SIDP_FUNC;
                  resume_reg <= 1'b1;
                end
              end
            end else begin
              // RL18: select needs exact identifier match, RL11
              if (sampled_bit != node_identifier[bcnt_reg[5:0]]) begin
                match_ok_reg <= 1'b0;
              end
              if (bcnt_reg == 7'd63) begin
                if (match_ok_reg && sampled_bit == node_identifier[63]) begin
                  state_reg <= sidp_pkg::SIDP_FUNC;
                  resume_reg <= 1'b1;
                end else begin
                  state_reg <= sidp_pkg::SIDP_MUTE;
                  resume_reg <= 1'b0;
                  if (pend_fast_reg) begin
                    fast_mode_flag <= 1'b0;
                  end
                end
                pend_fast_reg <= 1'b0;
              end
            end
          end
          sidp_pkg::SIDP_FUNC: begin
            // RL3: function bytes only after identity success
            if (bcnt_reg[2:0] == 3'd7) begin
              func_rx_byte <= {sampled_bit, sh_reg[7:1]};
              func_rx_valid <= 1'b1;
              if (bcnt_reg == 7'd7) begin
                func_cmd <= {sampled_bit, sh_reg[7:1]};
                func_cmd_valid <= 1'b1;
              end
            end
            if (bcnt_reg == 7'd127) begin
              bcnt_reg <= 7'd8;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end
  assign func_active = (state_reg == sidp_pkg::SIDP_FUNC);
  // ---------------------------------
  // function data transmit, lsb first
  // ---------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst || rst_pulse) begin
      tx_reg <= 8'h00;
      txc_reg <= 3'd0;
      tx_active_reg <= 1'b0;
    end else if (func_tx_load && func_active) begin
      tx_reg <= func_tx_byte;
      txc_reg <= 3'd0;
      tx_active_reg <= 1'b1;
    end else if (bit_strobe && tx_active_reg) begin
      txc_reg <= txc_reg + 3'd1;
      if (txc_reg == 3'd7) begin
        tx_active_reg <= 1'b0;
      end
    end
  end
  // ---------------------------------
  // user memory, one-time programmable blocks
  // ---------------------------------
  logic in_range;
  logic [2:0] blk;
  // RL12: address window
  assign in_range = (mem_addr >= sidp_pkg::MEM_FIRST) && (mem_addr <= sidp_pkg::MEM_LAST);
  assign blk = mem_addr[4:2];
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mem_rdata <= 8'h00;
    end else begin
      mem_rdata <= in_range ? mem_reg[mem_addr] : sidp_pkg::MEM_ERASED;
    end
  end
  genvar gi;
  for (gi = 0; gi < sidp_pkg::MEM_BYTES; gi++) begin : g_mem
    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        // RL13: erased value
        mem_reg[gi] <= sidp_pkg::MEM_ERASED;
      end else if (prog_req && in_range && !prot_reg[blk] && blk == 3'(gi / 4)) begin
        // RL14: whole block, any bit value; RL20 guarded by protection
        mem_reg[gi] <= prog_data[(gi % 4) * 8 +: 8];
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prot_reg <= '0;
      prog_done <= 1'b0;
      prog_refused <= 1'b0;
    end else begin
      prog_done <= 1'b0;
      prog_refused <= 1'b0;
      if (prog_req) begin
        if (in_range && !prot_reg[blk]) begin
          // RL15: protect block after write
          prot_reg[blk] <= 1'b1;
          prog_done <= 1'b1;
        end else begin
          prog_refused <= 1'b1;
        end
      end
    end
  end
  // ---------------------------------
  // checks
  // ---------------------------------
  property p_prot_hold;
    @(posedge mclk) disable iff (sys_rst)
    (prog_req && in_range && prot_reg[blk]) |=>
      prog_refused && mem_reg[$past(mem_addr)] == $past(mem_reg[mem_addr]);
  endproperty
  a_prot_hold: assert property (p_prot_hold) else $error("protected block changed"); // RL20
  property p_prot_set;
    @(posedge mclk) disable iff (sys_rst)
    (prog_req && in_range && !prot_reg[blk]) |=> prog_done && prot_reg[$past(blk)];
  endproperty
  a_prot_set: assert property (p_prot_set) else $error("block not protected"); // RL15
  property p_func_gate;
    @(posedge mclk) disable iff (sys_rst)
    func_cmd_valid |-> $past(state_reg) == sidp_pkg::SIDP_FUNC;
  endproperty
  a_func_gate: assert property (p_func_gate) else $error("function before identity"); // RL3
  property p_fast_clear;
    @(posedge mclk) disable iff (sys_rst)
    (rst_pulse && low_cnt_reg >= RW'(RESET_CYC)) |=> !fast_mode_flag;
  endproperty
  a_fast_clear: assert property (p_fast_clear) else $error("fast mode kept"); // RL17
  property p_mute;
    @(posedge mclk) disable iff (sys_rst)
    (state_reg == sidp_pkg::SIDP_MUTE && !rst_pulse) |=> state_reg == sidp_pkg::SIDP_MUTE;
  endproperty
  a_mute: assert property (p_mute) else $error("left mute without reset"); // RL19
  property p_check_ok;
    @(posedge mclk) disable iff (sys_rst)
    (crc_cnt_reg == 7'(sidp_pkg::ID_BITS)) |-> id_check_ok;
  endproperty
  a_check_ok: assert property (p_check_ok) else $error("identifier check bad"); // RL10
  property p_erased;
    @(posedge mclk) disable iff (sys_rst)
    (!in_range) |=> mem_rdata == sidp_pkg::MEM_ERASED;
  endproperty
  a_erased: assert property (p_erased) else $error("out of range not zero"); // RL12
  property p_fast_skip;
    @(posedge mclk) disable iff (sys_rst)
    (bit_strobe && state_reg == sidp_pkg::SIDP_ROMCMD && bcnt_reg == 7'd7 && !rst_pulse &&
     {sampled_bit, sh_reg[7:1]} == sidp_pkg::CMD_FAST_SKIP) |=> fast_mode_flag;
  endproperty
  a_fast_skip: assert property (p_fast_skip) else $error("fast mode not entered"); // RL2
endmodule

// >>> test/sidp_master.sv
`timescale 1ns/100ps
module sidp_master (
  input wire logic mclk,
  input wire logic line,
  output logic mst_oe_n
);
  logic fast;

  initial begin
    fast = 1'b0;
    mst_oe_n = 1'b1;
  end

  // ----------------
  // slot primitives
  // ----------------
  task automatic bus_reset(input int n);
    @(posedge mclk);
    mst_oe_n <= 1'b0;
    repeat (n) @(posedge mclk);
    mst_oe_n <= 1'b1;
  endtask

  task automatic wait_presence(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 40000 && ok == 1'b0; i++) begin
      @(negedge mclk);
      ok = (line === 1'b0);
    end
    for (int i = 0; i < 40000 && line !== 1'b1; i++) @(negedge mclk);
    if (line !== 1'b1) ok = 1'b0;
    repeat (fast ? 200 : 1000) @(posedge mclk);
  endtask

  task automatic write_bit(input logic b);
    int lo;
    lo = b ? (fast ? 20 : 200) : (fast ? 300 : 3100);
    bus_reset(lo);
    repeat ((fast ? 400 : 3300) - lo) @(posedge mclk);
  endtask

  task automatic read_bit(output logic v);
    bus_reset(20);
    repeat (fast ? 130 : 2380) @(posedge mclk);
    @(negedge mclk);
    v = line;
    repeat (fast ? 300 : 4000) @(posedge mclk);
  endtask

  // ----------------
  // byte transfers
  // ----------------
  // eight bits, lsb first
  task automatic write_byte(input logic [7:0] d);
    for (int i = 0; i < 8; i++) write_bit(d[i]);
  endtask

  task automatic read_byte(output logic [7:0] d);
    for (int i = 0; i < 8; i++) read_bit(d[i]);
  endtask
endmodule

// >>> test/tb.sv
`timescale 1ns/100ps
module tb;
  localparam logic [7:0] FAM = 8'h3e; // arbitrary value
  localparam logic [47:0] SER = 48'h0012_3456_789a; // arbitrary value
  localparam int RST_LONG = 8000;
  localparam int RST_SHORT = 4000;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic mst_oe_n, bus_out, bus_oe_n, fast_mode_flag, func_active;
  logic func_cmd_valid, func_rx_valid, prog_done, prog_refused, id_check_ok;
  logic [7:0] func_cmd, func_rx_byte, mem_rdata;
  logic [7:0] func_tx_byte = 8'h00;
  logic func_tx_load = 1'b0;
  logic [4:0] mem_addr = 5'h00;
  logic prog_req = 1'b0;
  logic [31:0] prog_data = 32'h0000_0000;
  logic [63:0] node_identifier, exp_id;
  wire logic bus_line;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int cmd_seen = 0;
  logic [7:0] cmd_last = 8'h00;
  logic [7:0] rx_last = 8'h00;

  always #2.5 mclk = ~mclk;
  // open-drain line with pull-up
  assign bus_line = !mst_oe_n ? 1'b0 : (!bus_oe_n ? bus_out : 1'b1);

  sidp_slave #(.FAMILY_CODE(FAM), .SERIAL_NUM(SER), .RESET_CYC(RST_LONG),
    .FAST_RESET_CYC(RST_SHORT)) sidp_slave_inst (
    .mclk(mclk), .sys_rst(sys_rst), .bus_in(bus_line), .bus_out(bus_out),
    .bus_oe_n(bus_oe_n), .fast_mode_flag(fast_mode_flag), .func_active(func_active),
    .func_cmd(func_cmd), .func_cmd_valid(func_cmd_valid), .func_rx_byte(func_rx_byte),
    .func_rx_valid(func_rx_valid), .func_tx_byte(func_tx_byte),
    .func_tx_load(func_tx_load), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .prog_req(prog_req), .prog_data(prog_data), .prog_done(prog_done),
    .prog_refused(prog_refused), .node_identifier(node_identifier),
    .id_check_ok(id_check_ok));

  sidp_master sidp_master_inst (.mclk(mclk), .line(bus_line), .mst_oe_n(mst_oe_n));

  // ----------------
  // helpers
  // ----------------
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (func_cmd_valid === 1'b1) begin
      cmd_seen <= cmd_seen + 1;
      cmd_last <= func_cmd;
    end
    if (func_rx_valid === 1'b1) begin
      rx_last <= func_rx_byte;
    end
    if (cycles == 250000) begin
      bad_count++;
      report_and_stop();
    end
  end

  function automatic logic [7:0] crc8(input logic [63:0] v, input int n);
    logic [7:0] c;
    c = 8'h00;
    // x^8+x^5+x^4+1 in lsb-first form
    for (int i = 0; i < n; i++) c = (c[0] ^ v[i]) ? ((c >> 1) ^ 8'h8c) : (c >> 1);
    return c;
  endfunction

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    @(posedge mclk);
    mem_addr <= a;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    v = mem_rdata;
  endtask

  task automatic prog(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    mem_addr <= a;
    prog_data <= d;
    prog_req <= 1'b1;
    @(posedge mclk);
    prog_req <= 1'b0;
    r = 2'b00;
    repeat (3) begin
      @(negedge mclk);
      r = r | {prog_refused, prog_done};
    end
  endtask

  // reset, presence, then one identity code
  task automatic frame(input int n, input logic [7:0] cmd);
    logic ok;
    sidp_master_inst.bus_reset(n);
    sidp_master_inst.wait_presence(ok);
    chk("presence", 1'h1, ok);
    sidp_master_inst.write_byte(cmd);
  endtask

  task automatic quiet(input string nm);
    logic b;
    int n0;
    n0 = cmd_seen;
    sidp_master_inst.write_byte(8'h4b);
    sidp_master_inst.read_bit(b);
    chk("silent_line", 1'h1, b);
    chk("silent_cmds", 64'(n0), 64'(cmd_seen));
    chk("silent_func", 1'h0, func_active);
    $display("test %s done", nm);
  endtask

  // ----------------
  // scenarios
  // ----------------
  task automatic t_ident();
    exp_id = {8'h00, SER, FAM};
    exp_id[63:56] = crc8(exp_id, 56);
    repeat (70) @(posedge mclk);
    @(negedge mclk);
    chk("idle_fast", 1'h0, fast_mode_flag);
    chk("idle_line", 1'h1, bus_oe_n);
    chk("id_ok", 1'h1, id_check_ok);
    chk("family", FAM, node_identifier[7:0]);
    chk("serial", SER, node_identifier[55:8]);
    chk("check_byte", exp_id[63:56], node_identifier[63:56]);
    chk("residue", 8'h00, crc8(node_identifier, 64));
    $display("test ident done");
  endtask

  task automatic t_memory();
    logic [7:0] v;
    logic [1:0] r;
    for (int a = 0; a < 32; a++) begin
      rd(5'(a), v);
      chk("erased", 8'h00, v);
    end
    prog(5'h16, 32'h81c3_e7a5, r);
    chk("prog_first", 2'b01, r);
    for (int k = 0; k < 4; k++) begin
      rd(5'(20 + k), v);
      chk("block", 8'(32'h81c3_e7a5 >> (8 * k)), v);
    end
    prog(5'h14, 32'h0000_0000, r);
    chk("prog_again", 2'b10, r);
    rd(5'h17, v);
    chk("kept", 8'h81, v);
    rd(5'h13, v);
    chk("neighbour", 8'h00, v);
    $display("test memory done");
  endtask

  task automatic t_fast_skip();
    logic [7:0] v;
    int n0;
    frame(RST_LONG + 200, sidp_pkg::CMD_FAST_SKIP);
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    chk("fast_on", 1'h1, fast_mode_flag);
    chk("func_on", 1'h1, func_active);
    sidp_master_inst.fast = 1'b1;
    n0 = cmd_seen;
    sidp_master_inst.write_byte(8'h4b);
    repeat (20) @(posedge mclk);
    chk("cmd_count", 64'(n0 + 1), 64'(cmd_seen));
    chk("func_cmd", 8'h4b, cmd_last);
    chk("func_rx", 8'h4b, rx_last);
    @(posedge mclk);
    func_tx_byte <= 8'h96;
    func_tx_load <= 1'b1;
    @(posedge mclk);
    func_tx_load <= 1'b0;
    sidp_master_inst.read_byte(v);
    chk("tx_byte", 8'h96, v);
    chk("rx_echo", 8'h96, rx_last);
    $display("test fast_skip done");
  endtask

  task automatic t_read_id();
    logic b;
    frame(RST_SHORT + 200, sidp_pkg::CMD_READ_ID);
    for (int i = 0; i < 16; i++) begin
      sidp_master_inst.read_bit(b);
      chk("id_bit", exp_id[i], b);
    end
    chk("fast_kept", 1'h1, fast_mode_flag);
    $display("test read_id done");
  endtask

  task automatic t_select_miss();
    frame(RST_SHORT + 200, sidp_pkg::CMD_SELECT);
    for (int i = 0; i < 64; i++) sidp_master_inst.write_bit(exp_id[i] ^ 1'(i == 63));
    quiet("select_miss");
  endtask

  task automatic t_long_reset();
    sidp_master_inst.bus_reset(RST_LONG + 200);
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    chk("fast_off", 1'h0, fast_mode_flag);
    $display("test long_reset done");
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    t_ident();
    t_memory();
    t_fast_skip();
    t_read_id();
    t_select_miss();
    frame(RST_SHORT + 200, 8'h00);
    quiet("unknown_code");
    t_long_reset();
    report_and_stop();
  end
endmodule
